//--- shared/overtemp_warn_map.vh
/*
 * Register map and timing constants for the overtemperature warning
 * comparator. Assumes a 32-bit AXI4-Lite register port, 50 MHz clock.
 */
`ifndef OVERTEMP_WARN_MAP_VH
`define OVERTEMP_WARN_MAP_VH

// ----------------------------------------------------------------
// Register word indices; the byte address is four times the index
// ----------------------------------------------------------------
`define THRESHOLD_ADDR 16'hfe1a
`define THRESHOLD_INDEX 16'hfe1a
`define STATUS_INDEX 16'hfe1b
`define MASK_INDEX 16'hfe1c
`define ADDR_LSB 2

// ----------------------------------------------------------------
// Reset values and fields
// ----------------------------------------------------------------
`define THRESHOLD_RESET 8'hfa
`define THRESHOLD_MIN 8'h03
`define THRESHOLD_MAX 8'hfa
`define STATUS_WARN_BIT 0
`define STATUS_LEVEL_BIT 1
`define STATUS_RESET 2'b00
`define MASK_RESET 1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define DEBOUNCE_MS 100
`define CLOCK_KHZ 50000
`define DEBOUNCE_CYCLES (`DEBOUNCE_MS * `CLOCK_KHZ)

// ----------------------------------------------------------------
// AXI responses
// ----------------------------------------------------------------
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- hw/warn_debounce.v
/*
 * Debounce filter: output rises after the input has held high for
 * a full interval, and drops as soon as the input drops.
 * Assumes a synchronous single clock with asynchronous active-low reset.
 */
`timescale 1ns/1ns
module warn_debounce #(
    parameter CYCLES = 5000000,
    parameter WIDTH = 23
) (
    input wire sys_clk,
    input wire reset_n,
    input wire raw,
    output reg filtered_q
);
    reg [WIDTH-1:0] count_q;
    wire [31:0] last_full = CYCLES - 1;
    wire [WIDTH-1:0] last = last_full[WIDTH-1:0];

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            count_q <= {WIDTH{1'b0}};
            filtered_q <= 1'b0;
        end else if (!raw) begin
            // A lapse restarts the interval from zero.
            count_q <= {WIDTH{1'b0}};
            filtered_q <= 1'b0;
        end else if (count_q == last) begin
            filtered_q <= 1'b1;
        end else begin
            count_q <= count_q + 1'b1;
        end
    end
endmodule

//--- hw/overtemp_warning_compare.v
/*
 * Overtemperature warning comparator with an AXI4-Lite register port,
 * a 100 ms debounce and a sticky, maskable interrupt.
 * Assumes the sensor ADC result is synchronous to sys_clk.
 */
`timescale 1ns/1ns
`include "overtemp_warn_map.vh"

// Functional notes
// - Warning flag debounced by a 100 ms filter.
// - Threshold is register with zero MSB, 9 bits.
// - Compare only nine ADC MSBs.
// - Warn when reading below threshold.
// - One threshold step is 3.125 mV.
module overtemp_warning_compare #(
    parameter ADC_WIDTH = 12,
    parameter DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
    input wire sys_clk,
    input wire reset_n,
    input wire [ADC_WIDTH-1:0] sensor_adc,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [31:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg warning_q,
    output reg irq_q
);
    // ------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------
    // The code is a voltage in 3.125 mV steps; it is compared as is.
    reg [7:0] threshold_q;
    wire [8:0] threshold_9 = {1'b0, threshold_q};
    wire [8:0] reading_9 = sensor_adc[ADC_WIDTH-1:ADC_WIDTH-9];
    wire below = reading_9 < threshold_9;
    wire debounced;

    warn_debounce #(
        .CYCLES(DEBOUNCE_CYCLES),
        .WIDTH(23)
    ) u_debounce (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .raw(below),
        .filtered_q(debounced)
    );

    reg debounced_prev_q;
    wire warn_rise = debounced & ~debounced_prev_q;

    // ------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------
    reg aw_held_q;
    reg w_held_q;
    reg [15:0] aw_index_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg status_q;
    reg mask_q;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire aw_have = aw_held_q | aw_take;
    wire w_have = w_held_q | w_take;
    wire [15:0] aw_index = s_axi_awaddr[`ADDR_LSB+15:`ADDR_LSB];
    wire [15:0] aw_now = aw_take ? aw_index : aw_index_q;
    wire [31:0] wd_now = w_take ? s_axi_wdata : wdata_q;
    wire [3:0] ws_now = w_take ? s_axi_wstrb : wstrb_q;
    wire do_write = aw_have & w_have & ~s_axi_bvalid;
    wire wr_thr = do_write & (aw_now == `THRESHOLD_INDEX) & ws_now[0];
    wire wr_sts = do_write & (aw_now == `STATUS_INDEX) & ws_now[0];
    wire wr_msk = do_write & (aw_now == `MASK_INDEX) & ws_now[0];
    wire hit_w = (aw_now == `THRESHOLD_INDEX) |
        (aw_now == `STATUS_INDEX) | (aw_now == `MASK_INDEX);

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            aw_index_q <= 16'h0000;
            wdata_q <= 32'h0000_0000;
            wstrb_q <= 4'h0;
            threshold_q <= `THRESHOLD_RESET;
            mask_q <= `MASK_RESET;
        end else begin
            if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
            if (aw_take) begin
                aw_index_q <= aw_index;
                s_axi_awready <= 1'b0;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write) begin
                aw_held_q <= 1'b0;
                w_held_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= hit_w ? `RESP_OKAY : `RESP_SLVERR;
            end else begin
                aw_held_q <= aw_have;
                w_held_q <= w_have;
            end
            // Out-of-range codes are stored as written; software owns them.
            if (wr_thr) begin
                threshold_q <= wd_now[7:0];
            end
            if (wr_msk) begin
                mask_q <= wd_now[0];
            end
        end
    end

    // ------------------------------------------------------------
    // Status, interrupt and warning output
    // ------------------------------------------------------------
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            status_q <= 1'b0;
            debounced_prev_q <= 1'b0;
            warning_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            debounced_prev_q <= debounced;
            warning_q <= debounced;
            // A new event wins over a simultaneous write-one-to-clear.
            if (warn_rise) begin
                status_q <= 1'b1;
            end else if (wr_sts & wd_now[`STATUS_WARN_BIT]) begin
                status_q <= 1'b0;
            end
            irq_q <= (status_q | warn_rise) & mask_q;
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------
    wire [15:0] ar_index = s_axi_araddr[`ADDR_LSB+15:`ADDR_LSB];

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid & s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (ar_index)
                `THRESHOLD_INDEX: begin
                    s_axi_rdata <= {24'h00_0000, threshold_q};
                end
                `STATUS_INDEX: begin
                    s_axi_rdata <= {30'h0000_0000, debounced, status_q};
                end
                `MASK_INDEX: begin
                    s_axi_rdata <= {31'h0000_0000, mask_q};
                end
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end
    end
endmodule

//--- tb/sensor_model.sv
/* Sensor ADC source: the nine top bits follow level, the low bits churn.
   Assumes one rising-edge clock shared with the block. */
`timescale 1ns/1ns
module sensor_model (
    input wire sys_clk,
    input wire [8:0] level,
    output logic [11:0] sensor_adc = 12'h000
);
    logic [2:0] churn_q = 3'h0;
    // Low bits change every cycle so a compare that reads them shows up.
    always @(posedge sys_clk) begin
        churn_q <= churn_q + 3'h1;
        sensor_adc <= {level, churn_q};
    end
endmodule

//--- tb/overtemp_warning_compare_checker.sv
/* Checker for the warning comparator, bound to its top module.
   Assumes writes offer address and data together. */
`timescale 1ns/1ns
module overtemp_warning_compare_checker #(
    parameter ADC_WIDTH = 12,
    parameter DEBOUNCE_CYCLES = 16
) (
    input wire sys_clk,
    input wire reset_n,
    input wire [ADC_WIDTH-1:0] sensor_adc,
    input wire [31:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire s_axi_bvalid,
    input wire warning_q
);
    localparam int D = DEBOUNCE_CYCLES;
    logic [7:0] thr_q;
    logic [7:0] cnt_q;
    wire take = s_axi_awvalid && s_axi_awready && s_axi_wvalid;
    wire hit = take && s_axi_wready && s_axi_wstrb[0] &&
        s_axi_awaddr[17:2] == 16'hfe1a;
    wire below = sensor_adc[ADC_WIDTH-1 -: 9] < {1'b0, thr_q};
    // Counter saturates so a long hold cannot wrap and look like a lapse.
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            thr_q <= 8'hfa;
            cnt_q <= 8'h00;
        end else begin
            if (hit) thr_q <= s_axi_wdata[7:0];
            cnt_q <= !below ? 8'h00 : cnt_q + {7'h00, cnt_q != 8'hff};
        end
    end
    default clocking dc @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    property p_rise; $rose(warning_q) |-> cnt_q >= D; endproperty
    a_rise: assert property (p_rise) else $error("early warning");
    property p_high; cnt_q >= D + 4 |-> warning_q; endproperty
    a_high: assert property (p_high) else $error("no warning");
    property p_drop; !below ##1 !below |=> !warning_q; endproperty
    a_drop: assert property (p_drop) else $error("warning stuck");
    property p_hold; warning_q && below && $past(below) |=> warning_q;
    endproperty
    a_hold: assert property (p_hold) else $error("warning lost");
    property p_resp; take && s_axi_wready |=> s_axi_bvalid && !s_axi_awready;
    endproperty
    a_resp: assert property (p_resp) else $error("no write response");
    property p_free; $fell(s_axi_bvalid) |-> s_axi_awready && s_axi_wready;
    endproperty
    a_free: assert property (p_free) else $error("write port stuck");
    cover property ($rose(warning_q));
    cover property ($fell(warning_q));
    cover property (cnt_q != 8'h00 ##1 cnt_q == 8'h00 ##1 below);
endmodule
bind overtemp_warning_compare overtemp_warning_compare_checker #(
    .ADC_WIDTH(ADC_WIDTH),
    .DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)
) checker_i (.*);

//--- tb/overtemp_warning_compare_tb.sv
/* Bench for the warning comparator: AXI4-Lite tasks and directed tests.
   Assumes the sensor model and the bound checker are compiled first. */
`timescale 1ns/1ns
module overtemp_warning_compare_tb;
    localparam int D = 16;
    localparam [31:0] TH = 32'h0003_f868;
    localparam [31:0] ST = 32'h0003_f86c;
    localparam [31:0] MK = 32'h0003_f870;
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [8:0] level = 9'h1ff;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    wire s_axi_rvalid, warning_q, irq_q;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    wire [11:0] sensor_adc;
    int errors = 0, check_count = 0, cycles = 0;
    initial forever #10 sys_clk = ~sys_clk;
    sensor_model adc (.*);
    overtemp_warning_compare #(.DEBOUNCE_CYCLES(D)) uut (.*);
    task chk(input [31:0] got, input [31:0] exp);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task wr(input [31:0] a, input [31:0] d, input [1:0] er);
        @(posedge sys_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(posedge sys_clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
        chk(s_axi_bresp, er);
    endtask
    task rd(input [31:0] a, input [31:0] e, input [1:0] er);
        @(posedge sys_clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(posedge sys_clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, er);
    endtask
    task close_out;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // A hung handshake ends the run here rather than spinning forever.
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            close_out;
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        rd(TH, 32'h0000_00fa, 2'b00);
        rd(MK, 32'h0000_0000, 2'b00);
        rd(32'h0000_0010, 32'h0000_0000, 2'b10);
        wr(32'h0000_0010, 32'h0000_0001, 2'b10);
        // A write with the low strobe clear must leave the threshold alone.
        s_axi_wstrb <= 4'he;
        wr(TH, 32'h0000_0055, 2'b00);
        s_axi_wstrb <= 4'hf;
        rd(TH, 32'h0000_00fa, 2'b00);
        $display("test registers done");
        wr(TH, 32'h0000_0003, 2'b00);
        level <= 9'h002;
        repeat (D - 4) @(posedge sys_clk);
        level <= 9'h003;
        @(posedge sys_clk);
        level <= 9'h002;
        repeat (D - 4) @(posedge sys_clk);
        chk(warning_q, 32'h0000_0000);
        repeat (10) @(posedge sys_clk);
        chk(warning_q, 32'h0000_0001);
        chk(irq_q, 32'h0000_0000);
        rd(ST, 32'h0000_0003, 2'b00);
        wr(MK, 32'h0000_0001, 2'b00);
        repeat (2) @(posedge sys_clk);
        chk(irq_q, 32'h0000_0001);
        level <= 9'h003;
        repeat (4) @(posedge sys_clk);
        chk(warning_q, 32'h0000_0000);
        wr(ST, 32'h0000_0001, 2'b00);
        rd(ST, 32'h0000_0000, 2'b00);
        chk(irq_q, 32'h0000_0000);
        $display("test debounce and interrupt done");
        level <= 9'h1f9;
        wr(TH, 32'h0000_00fa, 2'b00);
        repeat (D + 6) @(posedge sys_clk);
        chk(warning_q, 32'h0000_0000);
        $display("test widening done");
        close_out;
    end
endmodule
